// File: design/fmac_pkg.sv
// Package for the fractional MAC / normalize / round datapath
package fmac_pkg;

  // Operation codes
  typedef enum logic [3:0] {
    FMAC_OP_MAC_R,
    FMAC_OP_MSU_R,
    FMAC_OP_MULT,
    FMAC_OP_MULT_R,
    FMAC_OP_L_MAC,
    FMAC_OP_L_MSU,
    FMAC_OP_L_MULT,
    FMAC_OP_MIXED,
    FMAC_OP_SCAN_S,
    FMAC_OP_NORM_S,
    FMAC_OP_SCAN_L,
    FMAC_OP_NORM_L,
    FMAC_OP_ROUND
  } fmac_op_t;

  // Issued request
  typedef struct packed {
    fmac_op_t    op;
    logic [31:0] acc;
    logic [15:0] src_a;
    logic [15:0] src_b;
  } fmac_req_t;

  // Answer
  typedef struct packed {
    logic [31:0] data;
    logic        is_short;
    logic        saturated;
  } fmac_rsp_t;

  // Operating mode bits as seen by the datapath
  typedef struct packed {
    logic sat_en;
    logic twos_round;
  } fmac_mode_t;

  localparam logic [15:0] FMAC_MIN16        = 16'h8000;
  localparam logic [15:0] FMAC_MAX16        = 16'h7fff;
  localparam logic [31:0] FMAC_MIN32        = 32'h80000000;
  localparam logic [31:0] FMAC_MAX32        = 32'h7fffffff;
  localparam logic [15:0] FMAC_ZERO_SCAN    = 16'h001f;
  localparam logic [15:0] FMAC_ZERO_NORM    = 16'h0000;
  localparam logic [15:0] FMAC_HALF_LSB     = 16'h8000;
  localparam int          FMAC_MODE_SETTLE  = 3;
  localparam int          FMAC_LATENCY      = 1;
  localparam logic [31:0] FMAC_RSP_RESET    = 32'h00000000;

endpackage

// File: design/fmac_sat.sv
// Limiter that clamps a wide signed value to 32 bits when enabled
`timescale 1ns/100ps
module fmac_sat
  import fmac_pkg::*;
#(
  parameter int IN_W = 34
) (
  input  wire logic [IN_W-1:0] val_in,
  input  wire logic            sat_en,
  output logic      [31:0]     val_out,
  output logic                 clipped
);

  // Overflow is any disagreement among bit 31 and the bits above it
  wire over_pos = ~val_in[IN_W-1] & (|val_in[IN_W-2:31]);
  wire over_neg = val_in[IN_W-1] & ~(&val_in[IN_W-2:31]);

  // Without saturation the value wraps, as plain two's complement does
  assign clipped = sat_en & (over_pos | over_neg);
  assign val_out = !clipped ? val_in[31:0] : (over_pos ? FMAC_MAX32 : FMAC_MIN32);

endmodule

// File: design/fmac_lzc.sv
// Sign-scan counter: left shifts needed to normalise a signed value
`timescale 1ns/100ps
module fmac_lzc
  import fmac_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic [W-1:0] val_in,
  output logic      [15:0]  count,
  output logic              is_zero
);

  logic [15:0] cnt_v;
  logic        done_v;

  // Count bits equal to the sign, below the sign bit, until the first change
  always_comb begin
    cnt_v  = 16'h0000;
    done_v = 1'b0;
    for (int i = W - 2; i >= 0; i--) begin
      if (!done_v && (val_in[i] == val_in[W-1])) begin
        cnt_v = cnt_v + 16'h0001;
      end else begin
        done_v = 1'b1;
      end
    end
  end

  assign count   = cnt_v;
  assign is_zero = (val_in == '0);

endmodule

// File: design/fmac_alu.sv
// Fractional multiply / MAC / normalize / round datapath with one-cycle latency
`timescale 1ns/100ps
module fmac_alu
  import fmac_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       req_valid,
  input  wire fmac_req_t  req,
  input  wire fmac_mode_t mode,
  output logic            rsp_valid,
  output fmac_rsp_t       rsp
);

  // ---------------------------------------------------------------
  // Operand decode
  // ---------------------------------------------------------------
  // The mode bits are used as presented; the issuer keeps them settled
  // ahead of time, so no staging is done here.
  wire logic signed [15:0] a16   = req.src_a;
  wire logic signed [15:0] b16   = req.src_b;
  wire logic signed [31:0] acc32 = req.acc;

  wire logic is_mac_r  = (req.op == FMAC_OP_MAC_R);
  wire logic is_msu_r  = (req.op == FMAC_OP_MSU_R);
  wire logic is_l_mac  = (req.op == FMAC_OP_L_MAC);
  wire logic is_l_msu  = (req.op == FMAC_OP_L_MSU);
  wire logic is_mixed  = (req.op == FMAC_OP_MIXED);
  wire logic is_sub    = is_msu_r | is_l_msu;
  wire logic use_acc   = is_mac_r | is_msu_r | is_l_mac | is_l_msu;

  // ---------------------------------------------------------------
  // Multipliers
  // ---------------------------------------------------------------
  // 16x16 raw product and its fractional alignment
  wire logic signed [31:0] prod_raw = a16 * b16;
  wire logic [31:0]        prod_frac = {prod_raw[30:0], 1'b0};
  // Only -1 x -1 leaves the fractional range
  wire logic both_min16 = (req.src_a == FMAC_MIN16) && (req.src_b == FMAC_MIN16);

  // 32x16 mixed product; keep the upper 32 bits of the aligned 48-bit result
  wire logic signed [47:0] mix_raw  = acc32 * b16;
  wire logic [31:0]        mix_frac = mix_raw[46:15];
  wire logic both_min_mix = (req.acc == FMAC_MIN32) && (req.src_b == FMAC_MIN16);

  // Multiply results with the single overflow case clamped when enabled
  wire logic        mul_clip = mode.sat_en & both_min16;
  wire logic [31:0] mul_val  = mul_clip ? FMAC_MAX32 : prod_frac;
  wire logic        mix_clip = mode.sat_en & both_min_mix;
  wire logic [31:0] mix_val  = mix_clip ? FMAC_MAX32 : mix_frac;

  // ---------------------------------------------------------------
  // Accumulate path with output limiter
  // ---------------------------------------------------------------
  // Two guard bits: the aligned product can itself reach +1.0
  wire logic [33:0] acc_ext  = {{2{acc32[31]}}, req.acc};
  wire logic [33:0] prod_ext = {2'b00, prod_frac} | {{2{prod_frac[31] & ~both_min16}}, 32'h00000000};
  wire logic [33:0] sum_ext  = is_sub ? (acc_ext - prod_ext) : (acc_ext + prod_ext);
  logic [31:0] mac_lim;
  logic        mac_clip;

  // This limiter sits on the accumulate output; the rounded value has its own
  fmac_sat #(
    .IN_W (34)
  ) u_mac_sat (
    .val_in  (sum_ext),
    .sat_en  (mode.sat_en),
    .val_out (mac_lim),
    .clipped (mac_clip)
  );

  // ---------------------------------------------------------------
  // Rounding 32 -> 16
  // ---------------------------------------------------------------
  // Source of rounding: the un-limited sum for the MAC forms, else the
  // product or the round operand; limiting happens after the add
  wire logic [33:0] rnd_src =
    (is_mac_r | is_msu_r)        ? sum_ext :
    (req.op == FMAC_OP_MULT_R)   ? {2'b00, prod_frac} | {{2{prod_frac[31] & ~both_min16}}, 32'h00000000} :
                                   {{2{acc32[31]}}, req.acc};
  wire logic [33:0] rnd_add  = rnd_src + {18'h00000, FMAC_HALF_LSB};
  // Exact half: low word was 0x8000, so after the add it is zero
  wire logic        tie      = (rnd_src[15:0] == FMAC_HALF_LSB);
  // Convergent rounding clears the result LSB on a tie
  wire logic        conv_fix = ~mode.twos_round & tie;
  wire logic [33:0] rnd_pre  = {rnd_add[33:17], rnd_add[16] & ~conv_fix, 16'h0000};
  logic [31:0] rnd_lim;
  logic        rnd_clip;

  // Same limiter applied to the rounded value
  fmac_sat #(
    .IN_W (34)
  ) u_rnd_sat (
    .val_in  (rnd_pre),
    .sat_en  (mode.sat_en),
    .val_out (rnd_lim),
    .clipped (rnd_clip)
  );

  // ---------------------------------------------------------------
  // Normalisation counts
  // ---------------------------------------------------------------
  logic [15:0] cnt16;
  logic [15:0] cnt32;
  logic        zero16;
  logic        zero32;

  fmac_lzc #(
    .W (16)
  ) u_lzc16 (
    .val_in  (req.src_a),
    .count   (cnt16),
    .is_zero (zero16)
  );

  fmac_lzc #(
    .W (32)
  ) u_lzc32 (
    .val_in  (req.acc),
    .count   (cnt32),
    .is_zero (zero32)
  );

  // Zero has no sign change; the two conventions differ only there
  wire logic [15:0] scan_s = zero16 ? FMAC_ZERO_SCAN : cnt16;
  wire logic [15:0] norm_s = zero16 ? FMAC_ZERO_NORM : cnt16;
  wire logic [15:0] scan_l = zero32 ? FMAC_ZERO_SCAN : cnt32;
  wire logic [15:0] norm_l = zero32 ? FMAC_ZERO_NORM : cnt32;

  // ---------------------------------------------------------------
  // Result selection
  // ---------------------------------------------------------------
  // Short results sit in the high half with the low portion zeroed, as
  // they would land in an accumulator
  logic [31:0] res_next;
  logic        short_next;
  logic        sat_next;

  always_comb begin
    res_next   = FMAC_RSP_RESET;
    short_next = 1'b1;
    sat_next   = 1'b0;
    case (req.op)
      FMAC_OP_MAC_R, FMAC_OP_MSU_R, FMAC_OP_MULT_R, FMAC_OP_ROUND: begin
        res_next = {rnd_lim[31:16], 16'h0000};
        sat_next = rnd_clip;
      end
      FMAC_OP_MULT: begin
        res_next = {mul_val[31:16], 16'h0000};
        sat_next = mul_clip;
      end
      FMAC_OP_L_MAC, FMAC_OP_L_MSU: begin
        res_next   = mac_lim;
        short_next = 1'b0;
        sat_next   = mac_clip;
      end
      FMAC_OP_L_MULT: begin
        res_next   = mul_val;
        short_next = 1'b0;
        sat_next   = mul_clip;
      end
      FMAC_OP_MIXED: begin
        res_next   = mix_val;
        short_next = 1'b0;
        sat_next   = mix_clip;
      end
      FMAC_OP_SCAN_S: res_next = {scan_s, 16'h0000};
      FMAC_OP_NORM_S: res_next = {norm_s, 16'h0000};
      FMAC_OP_SCAN_L: res_next = {scan_l, 16'h0000};
      FMAC_OP_NORM_L: res_next = {norm_l, 16'h0000};
      default: begin
        res_next = FMAC_RSP_RESET;
        sat_next = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic      rsp_valid_reg;
  fmac_rsp_t rsp_reg;

  // One register stage so every output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
    end else begin
      rsp_valid_reg <= req_valid;
      if (req_valid) begin
        rsp_reg <= '{data: res_next, is_short: short_next, saturated: sat_next};
      end
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp       = rsp_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_short_low_clear;
    @(posedge sys_clk) disable iff (rst)
    rsp_valid && rsp.is_short |-> rsp.data[15:0] == 16'h0000;
  endproperty
  a_short_low_clear: assert property (p_short_low_clear) else $error("low portion not cleared");

  property p_mult_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_MULT && mode.sat_en && req.src_a == 16'h8000 && req.src_b == 16'h8000
      |=> rsp.data == 32'h7fff0000 && rsp.saturated;
  endproperty
  a_mult_sat: assert property (p_mult_sat) else $error("mult did not saturate");

  property p_lmult_only_min;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_L_MULT && !(req.src_a == 16'h8000 && req.src_b == 16'h8000)
      |=> !rsp.saturated;
  endproperty
  a_lmult_only_min: assert property (p_lmult_only_min) else $error("long mult saturated wrongly");

  property p_mixed_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_MIXED && mode.sat_en && req.acc == 32'h80000000 && req.src_b == 16'h8000
      |=> rsp.data == 32'h7fffffff;
  endproperty
  a_mixed_sat: assert property (p_mixed_sat) else $error("mixed mult did not saturate");

  property p_scan_zero;
    @(posedge sys_clk) disable iff (rst)
    req_valid && (req.op == FMAC_OP_SCAN_S) && req.src_a == 16'h0000 |=> rsp.data[31:16] == 16'h001f;
  endproperty
  a_scan_zero: assert property (p_scan_zero) else $error("short scan of zero not 31");

  property p_norm_zero;
    @(posedge sys_clk) disable iff (rst)
    req_valid && (req.op == FMAC_OP_NORM_L) && req.acc == 32'h0 |=> rsp.data[31:16] == 16'h0000;
  endproperty
  a_norm_zero: assert property (p_norm_zero) else $error("long norm of zero not 0");

  property p_nosat_wrap;
    @(posedge sys_clk) disable iff (rst)
    req_valid && !mode.sat_en |=> !rsp.saturated;
  endproperty
  a_nosat_wrap: assert property (p_nosat_wrap) else $error("saturated while disabled");

  property p_round_conv;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_ROUND && !mode.twos_round && req.acc == 32'h00018000
      |=> rsp.data == 32'h00020000;
  endproperty
  a_round_conv: assert property (p_round_conv) else $error("convergent tie wrong");

  property p_round_twos;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_ROUND && mode.twos_round && req.acc == 32'h00008000
      |=> rsp.data == 32'h00010000;
  endproperty
  a_round_twos: assert property (p_round_twos) else $error("two's complement round wrong");

  property p_valid_follows;
    @(posedge sys_clk) disable iff (rst)
    req_valid |=> rsp_valid;
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("answer missing");

  // Near-full accumulator plus a quarter must clamp, not wrap negative
  property p_mac_r_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && is_mac_r && mode.sat_en && req.acc == FMAC_MAX32
      && req.src_a == 16'h4000 && req.src_b == 16'h4000
      |=> rsp.data == 32'h7fff0000 && rsp.saturated;
  endproperty
  a_mac_r_sat: assert property (p_mac_r_sat) else $error("rounded MAC did not saturate");

  property p_msu_r_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && is_msu_r && mode.sat_en && req.acc == FMAC_MIN32 && both_min16
      |=> rsp.data == 32'h80000000 && rsp.saturated;
  endproperty
  a_msu_r_sat: assert property (p_msu_r_sat) else $error("rounded MSU did not saturate");

  property p_mult_r_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_MULT_R && mode.sat_en && both_min16
      |=> rsp.data == 32'h7fff0000 && rsp.saturated;
  endproperty
  a_mult_r_sat: assert property (p_mult_r_sat) else $error("rounded mult did not saturate");

  property p_l_mac_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && is_l_mac && mode.sat_en && req.acc == FMAC_MAX32
      && req.src_a == 16'h4000 && req.src_b == 16'h4000
      |=> rsp.data == FMAC_MAX32 && rsp.saturated;
  endproperty
  a_l_mac_sat: assert property (p_l_mac_sat) else $error("long MAC did not saturate");

  property p_l_msu_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && is_l_msu && mode.sat_en && req.acc == FMAC_MIN32 && both_min16
      |=> rsp.data == FMAC_MIN32 && rsp.saturated;
  endproperty
  a_l_msu_sat: assert property (p_l_msu_sat) else $error("long MSU did not saturate");

  property p_mixed_only_min;
    @(posedge sys_clk) disable iff (rst)
    req_valid && is_mixed && !both_min_mix
      |=> !rsp.saturated;
  endproperty
  a_mixed_only_min: assert property (p_mixed_only_min) else $error("mixed mult saturated wrongly");

  property p_norm_s_zero;
    @(posedge sys_clk) disable iff (rst)
    req_valid && (req.op == FMAC_OP_NORM_S) && req.src_a == 16'h0000 |=> rsp.data[31:16] == 16'h0000;
  endproperty
  a_norm_s_zero: assert property (p_norm_s_zero) else $error("short norm of zero not 0");

  property p_scan_l_zero;
    @(posedge sys_clk) disable iff (rst)
    req_valid && (req.op == FMAC_OP_SCAN_L) && req.acc == 32'h00000000 |=> rsp.data[31:16] == 16'h001f;
  endproperty
  a_scan_l_zero: assert property (p_scan_l_zero) else $error("long scan of zero not 31");

  // Rounding up past the top must clamp in either rounding mode
  property p_round_sat;
    @(posedge sys_clk) disable iff (rst)
    req_valid && req.op == FMAC_OP_ROUND && mode.sat_en && req.acc == 32'h7fff8000
      |=> rsp.data == 32'h7fff0000 && rsp.saturated;
  endproperty
  a_round_sat: assert property (p_round_sat) else $error("round did not saturate");

  property p_long_mac_full;
    @(posedge sys_clk) disable iff (rst)
    req_valid && use_acc && !is_mac_r && !is_msu_r |=> !rsp.is_short;
  endproperty
  a_long_mac_full: assert property (p_long_mac_full) else $error("long MAC marked short");

endmodule

// File: dv/fmac_alu_bench.sv
// Self-checking bench for the fractional MAC / normalize / round datapath
`timescale 1ns/100ps
module fmac_alu_bench
  import fmac_pkg::*;
;
  // ----------------------------------------
  // Signals and operand tables
  // ----------------------------------------
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        req_valid = 1'b0;
  fmac_req_t   req       = '0;
  fmac_mode_t  mode      = '0;
  logic        rsp_valid;
  fmac_rsp_t   rsp;
  logic        pend      = 1'b0;
  fmac_rsp_t   exp_rsp   = '0;
  fmac_op_t    exp_op    = FMAC_OP_MAC_R;
  int          err_total = 0;
  int          checked   = 0;
  int          seed      = 53;
  wire  [34:0] want      = {pend, exp_rsp};
  wire  [34:0] seen      = {rsp_valid, rsp};
  // Ties, overflow edges, zero and most-negative operands
  logic [31:0] acc_tab [12] = '{32'h0000ffff, 32'h20000000, 32'h80000000, 32'h7fffffff, 32'h12348000,
                                32'h12358000, 32'h7fff8000, 32'h00000000, 32'h80000000, 32'hffffffff,
                                32'h00018000, 32'h00008000};
  logic [15:0] a_tab   [12] = '{16'hc000, 16'hc000, 16'h8000, 16'h4000, 16'h0000,
                                16'hffff, 16'h8000, 16'h2000, 16'h7fff, 16'h0001, 16'h0003, 16'h7fff};
  logic [15:0] b_tab   [12] = '{16'h4000, 16'h4000, 16'h8000, 16'h4000, 16'h0000,
                                16'h2000, 16'h7fff, 16'h2000, 16'h8000, 16'hffff, 16'h0005, 16'h8001};

  always #2.5 sys_clk = ~sys_clk;

  fmac_alu dut (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .req_valid (req_valid),
    .req       (req),
    .mode      (mode),
    .rsp_valid (rsp_valid),
    .rsp       (rsp)
  );

  // ----------------------------------------
  // Reference model, wide integers so overflow is seen before clamping
  // ----------------------------------------
  function automatic fmac_rsp_t model(fmac_req_t q, fmac_mode_t m);
    longint      hi, p, s, r;
    int          n;
    logic [31:0] v;
    fmac_rsp_t   e;
    hi = 64'h7fffffff;
    p = 2 * longint'($signed(q.src_a)) * longint'($signed(q.src_b));
    s = longint'($signed(q.acc));
    e = '0;
    e.is_short = 1'b1;
    case (q.op)
      FMAC_OP_MAC_R, FMAC_OP_L_MAC: r = s + p;
      FMAC_OP_MSU_R, FMAC_OP_L_MSU: r = s - p;
      FMAC_OP_MULT, FMAC_OP_MULT_R, FMAC_OP_L_MULT: r = p;
      FMAC_OP_ROUND: r = s;
      FMAC_OP_MIXED: r = (s * longint'($signed(q.src_b))) >>> 15;
      default: r = 0;
    endcase
    if (q.op inside {FMAC_OP_MAC_R, FMAC_OP_MSU_R, FMAC_OP_MULT_R, FMAC_OP_ROUND}) begin
      n = (!m.twos_round && r[15:0] == 16'h8000);
      r = r + 64'sh8000;
      if (n != 0) r[16] = 1'b0;
    end
    if (m.sat_en && r > hi) begin
      r = hi;
      e.saturated = 1'b1;
    end else if (m.sat_en && r < -hi - 1) begin
      r = -hi - 1;
      e.saturated = 1'b1;
    end
    if (q.op inside {FMAC_OP_L_MAC, FMAC_OP_L_MSU, FMAC_OP_L_MULT, FMAC_OP_MIXED}) e.is_short = 1'b0;
    e.data = r[31:0];
    if (e.is_short) e.data[15:0] = 16'h0000;
    if (q.op inside {[FMAC_OP_SCAN_S:FMAC_OP_NORM_L]}) begin
      v = (q.op inside {FMAC_OP_SCAN_S, FMAC_OP_NORM_S}) ? {q.src_a, 16'h0000} : q.acc;
      n = 0;
      while (n < 31 && v[30-n] == v[31]) n++;
      if (v == 32'h0) n = (q.op inside {FMAC_OP_SCAN_S, FMAC_OP_SCAN_L}) ? 31 : 0;
      e.data = {16'(n), 16'h0000};
    end
    return e;
  endfunction

  // Expected answer one cycle after each accepted request, held otherwise
  always @(posedge sys_clk) begin
    if (rst) begin
      pend <= 1'b0;
      exp_rsp <= '0;
    end else begin
      pend <= req_valid;
      if (req_valid) begin
        exp_rsp <= model(req, mode);
        exp_op <= req.op;
      end
    end
  end

  task automatic chk(input string what, input logic [34:0] e, input logic [34:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  // Compare mid-cycle, where every output has settled
  always @(negedge sys_clk) begin
    if (exp_op inside {FMAC_OP_L_MAC, FMAC_OP_L_MSU, FMAC_OP_L_MULT, FMAC_OP_MIXED})
      chk("long result", want, seen);
    else if (exp_op inside {[FMAC_OP_SCAN_S:FMAC_OP_NORM_L]})
      chk("count", want, seen);
    else
      chk("short result", want, seen);
  end

  // ----------------------------------------
  // Drivers, always 1 ns after the rising edge
  // ----------------------------------------
  task automatic issue(input int o, input logic [31:0] acc, input logic [15:0] a, input logic [15:0] b);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req = '{fmac_op_t'(o[3:0]), acc, a, b};
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
    end
  endtask

  // Mode only moves while idle, then stays put well past the settle time
  task automatic set_mode(input logic [1:0] md);
    idle(1);
    mode = fmac_mode_t'(md);
    idle(FMAC_MODE_SETTLE + 1);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r1;
    logic [15:0] a;
    logic [15:0] b;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    // Every operation against every table row in all four modes, back to back
    for (int md = 0; md < 4; md++) begin
      set_mode(md[1:0]);
      for (int o = 0; o < 13; o++)
        for (int k = 0; k < 12; k++) issue(o, acc_tab[k], a_tab[k], b_tab[k]);
    end
    idle(2);
    $display("test directed done");
    // Reset right behind a request, with a request offered during reset
    issue(0, 32'h12345678, 16'h4000, 16'h4000);
    idle(1);
    rst = 1'b1;
    issue(1, 32'h0, 16'h4000, 16'h4000);
    idle(2);
    rst = 1'b0;
    idle(2);
    $display("test reset done");
    // Random traffic with gaps, extremes forced now and then
    for (int i = 0; i < 400; i++) begin
      if (i % 40 == 0) set_mode(2'($random(seed)));
      if ($random(seed) % 4 == 0) idle(1);
      r1 = $random(seed);
      a = 16'($random(seed));
      b = 16'($random(seed));
      if (a[2:0] == 3'h0) a = 16'h8000;
      if (b[2:0] == 3'h0) b = 16'h8000;
      if (r1[3:0] == 4'h0) r1 = 32'h80000000;
      issue($unsigned($random(seed)) % 13, r1, a, b);
    end
    idle(3);
    $display("test random done");
    give_verdict();
  end

  // Whole run is near 1200 cycles; ten thousand means a hang
  initial begin
    #50000;
    err_total++;
    give_verdict();
  end
endmodule
